// >>> verilog/tic_top.sv
// Base timer and interrupt controller with an AXI4-Lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "tic_map.svh"

module tic_top
  import tic_pkg::*;
#(
  parameter int KEY_TICK_CYC = `TIC_KEY_TICK_CYC,
  parameter int POR_CYC = `TIC_POR_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic ep0_tx_done,
  input wire logic ep0_rx_done,
  input wire logic ep1_tx_done,
  input wire logic ep2_tx_done,
  input wire logic ep0_setup_done,
  input wire logic bus_sleep_flag,
  output logic cpu_irq,
  output logic cpu_clk_en,
  output logic chip_reset_n
);

  // Power-on hold: internal reset stays low POR_CYC cycles after aresetn
  tic_por_e por_state_r;
  tic_por_e por_state_nxt;
  logic [31:0] por_cnt_r;
  wire sys_rst_n = aresetn && (por_state_r == TIC_POR_RUN);
  wire por_done = (por_cnt_r == 32'(POR_CYC - 1));

  always_comb begin
    case (por_state_r)
      TIC_POR_HOLD: por_state_nxt = por_done ? TIC_POR_RUN : TIC_POR_HOLD;
      TIC_POR_RUN: por_state_nxt = TIC_POR_RUN;
      default: por_state_nxt = TIC_POR_HOLD;
    endcase
  end

  // External reset restarts the hold, so either source resets the whole block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_state_r <= TIC_POR_HOLD;
      por_cnt_r <= 32'h0000_0000;
    end else begin
      por_state_r <= por_state_nxt;
      por_cnt_r <= por_done ? por_cnt_r : por_cnt_r + 32'h0000_0001;
    end
  end

  // Core clock enable toggles every cycle, so it is high at half the system rate
  logic core_phase_r;
  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      core_phase_r <= 1'b0;
    end else begin
      core_phase_r <= ~core_phase_r;
    end
  end

  // Write channel: address and data are taken in either order, then answered
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
  wire [3:0] wr_idx = aw_held_r ? aw_idx_r : s_axi_awaddr[5:2];
  wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire wr_lane0 = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];
  wire wr_fire = (aw_held_r || aw_take) && (w_held_r || w_take);
  wire wr_hit = wr_idx <= `TIC_IDX_LAST;
  wire wr_go = wr_fire && wr_hit && wr_lane0;

  // Pure decode: every operand is an argument, so continuous users see each change
  function automatic logic wr_to(input logic go, input logic [3:0] at, input logic [3:0] idx);
    return go && (at == idx);
  endfunction

  // Register selects, one per writable register
  wire sel_func_en = wr_to(wr_go, wr_idx, `TIC_IDX_FUNC_ENABLE);
  wire sel_usb_en = wr_to(wr_go, wr_idx, `TIC_IDX_USB_ENABLE);
  wire sel_run = wr_to(wr_go, wr_idx, `TIC_IDX_RUN_CONTROL);
  wire sel_prescale = wr_to(wr_go, wr_idx, `TIC_IDX_PRESCALE);
  wire sel_preset = wr_to(wr_go, wr_idx, `TIC_IDX_TIMER_PRESET);
  wire sel_func_clr = wr_to(wr_go, wr_idx, `TIC_IDX_FUNC_CLEAR);
  wire sel_usb_clr = wr_to(wr_go, wr_idx, `TIC_IDX_USB_CLEAR);

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `TIC_RESP_OKAY;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[5:2];
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Software-written registers
  logic [7:0] func_en_r;
  logic [7:0] usb_en_r;
  logic run_n_r;
  logic [2:0] prescale_r;
  wire [7:0] wr_byte = wr_data[7:0];

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      func_en_r <= `TIC_RST_ENABLE;
      usb_en_r <= `TIC_RST_ENABLE;
      run_n_r <= `TIC_RST_RUN_CONTROL;
      prescale_r <= `TIC_RST_PRESCALE;
    end else begin
      if (sel_func_en) begin
        func_en_r <= wr_byte & `TIC_FUNC_MASK;
      end
      if (sel_usb_en) begin
        usb_en_r <= wr_byte & `TIC_USB_MASK;
      end
      if (sel_run) begin
        run_n_r <= wr_byte[0];
      end
      if (sel_prescale) begin
        prescale_r <= wr_byte[2:0];
      end
    end
  end

  // Prescaler: divider held at zero while stopped; the selected bit's carry steps the timer
  logic [`TIC_PRESCALE_W-1:0] pre_cnt_r;
  logic [7:0] timer_r;
  wire [`TIC_PRESCALE_W-1:0] pre_sel = `TIC_PRESCALE_W'(1) << (prescale_r + 4'(`TIC_PRESCALE_BASE) - 4'h1);
  wire [`TIC_PRESCALE_W-1:0] pre_top = (pre_sel << 1) - `TIC_PRESCALE_W'(1);
  wire pre_tick = ((pre_cnt_r & pre_top) == pre_top);
  wire timer_step = !run_n_r && pre_tick;
  wire timer_ovf = timer_step && (timer_r == `TIC_TIMER_MAX);

  // Preset write wins over counting, so a load is exact whether or not running
  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      pre_cnt_r <= '0;
      timer_r <= `TIC_TIMER_ZERO;
    end else begin
      pre_cnt_r <= run_n_r ? '0 : pre_cnt_r + `TIC_PRESCALE_W'(1);
      if (sel_preset) begin
        timer_r <= wr_byte;
      end else if (timer_step) begin
        timer_r <= timer_r + 8'h01;
      end
    end
  end

  // Key report tick every 4 ms
  logic [31:0] key_cnt_r;
  wire key_tick = (key_cnt_r == 32'(KEY_TICK_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      key_cnt_r <= 32'h0000_0000;
    end else begin
      key_cnt_r <= key_tick ? 32'h0000_0000 : key_cnt_r + 32'h0000_0001;
    end
  end

  // External pin edges, synchronised first
  wire ext_a_fall;
  wire ext_b_fall;
  tic_falling_edge u_edge_a (
    .aclk(aclk),
    .aresetn(sys_rst_n),
    .pin(ext_irq_a),
    .fall(ext_a_fall)
  );
  tic_falling_edge u_edge_b (
    .aclk(aclk),
    .aresetn(sys_rst_n),
    .pin(ext_irq_b),
    .fall(ext_b_fall)
  );

  // Hardware set vectors
  wire [7:0] func_set;
  wire [7:0] usb_set;
  assign func_set[`TIC_BIT_TMR] = timer_ovf;
  assign func_set[`TIC_BIT_EXT_A] = ext_a_fall;
  assign func_set[`TIC_BIT_EXT_B] = ext_b_fall;
  assign func_set[`TIC_BIT_KEY] = key_tick;
  assign func_set[7:4] = 4'h0;
  assign usb_set[`TIC_BIT_EP0_TX] = ep0_tx_done;
  assign usb_set[`TIC_BIT_EP0_RX] = ep0_rx_done;
  assign usb_set[`TIC_BIT_EP1_TX] = ep1_tx_done;
  assign usb_set[`TIC_BIT_EP2_TX] = ep2_tx_done;
  assign usb_set[5:4] = 2'h0;
  assign usb_set[`TIC_BIT_SETUP] = ep0_setup_done;
  assign usb_set[`TIC_BIT_SLEEP] = bus_sleep_flag;

  // Write-one-to-clear; a set in the same cycle wins over the clear
  function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] set,
                                           input logic [7:0] clr, input logic [7:0] mask);
    return ((cur & ~clr) | set) & mask;
  endfunction

  logic [7:0] func_flags_r;
  logic [7:0] usb_flags_r;
  wire [7:0] func_clr = sel_func_clr ? wr_byte : 8'h00;
  wire [7:0] usb_clr = sel_usb_clr ? wr_byte : 8'h00;

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      func_flags_r <= `TIC_RST_FLAGS;
      usb_flags_r <= `TIC_RST_FLAGS;
    end else begin
      func_flags_r <= flag_next(func_flags_r, func_set, func_clr, `TIC_FUNC_MASK);
      usb_flags_r <= flag_next(usb_flags_r, usb_set, usb_clr, `TIC_USB_MASK);
    end
  end

  // Shared request: any flag with its enable; disabled flags stay readable
  wire irq_any = |(func_flags_r & func_en_r) || |(usb_flags_r & usb_en_r);

  // Outputs straight from flops
  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      cpu_irq <= 1'b0;
      cpu_clk_en <= 1'b0;
      chip_reset_n <= 1'b0;
    end else begin
      cpu_irq <= irq_any;
      cpu_clk_en <= core_phase_r;
      chip_reset_n <= 1'b1;
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  // Write-only registers read as zero
  wire [7:0] rd_byte = (rd_idx == `TIC_IDX_FUNC_FLAGS) ? func_flags_r :
                       (rd_idx == `TIC_IDX_FUNC_ENABLE) ? func_en_r :
                       (rd_idx == `TIC_IDX_USB_FLAGS) ? usb_flags_r :
                       (rd_idx == `TIC_IDX_USB_ENABLE) ? usb_en_r :
                       (rd_idx == `TIC_IDX_PRESCALE) ? {5'h00, prescale_r} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TIC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= (rd_idx <= `TIC_IDX_LAST) ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Ready lines are registered: each flop holds what the accept term is next cycle,
  // so awready and wready still equal !held && !bvalid, and arready !rvalid, but each leaves straight from a flip-flop
  logic awready_r;
  logic wready_r;
  logic arready_r;
  wire bvalid_keep = bvalid_r && !s_axi_bready;
  wire rvalid_keep = rvalid_r && !s_axi_rready;
  wire awready_nxt = !wr_fire && !aw_held_r && !aw_take && !bvalid_keep;
  wire wready_nxt = !wr_fire && !w_held_r && !w_take && !bvalid_keep;
  wire arready_nxt = !ar_take && !rvalid_keep;

  always_ff @(posedge aclk) begin
    if (!sys_rst_n) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // Bus outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule
`default_nettype wire

// >>> verilog/tic_map.svh
// Register map, field positions and timing constants of the timer interrupt controller
`ifndef TIC_MAP_SVH
`define TIC_MAP_SVH
// Register indexes; byte address is four times the index
`define TIC_IDX_FUNC_FLAGS 4'h0
`define TIC_IDX_FUNC_CLEAR 4'h1
`define TIC_IDX_FUNC_ENABLE 4'h2
`define TIC_IDX_USB_FLAGS 4'h3
`define TIC_IDX_USB_CLEAR 4'h4
`define TIC_IDX_USB_ENABLE 4'h5
`define TIC_IDX_TIMER_PRESET 4'h6
`define TIC_IDX_RUN_CONTROL 4'h7
`define TIC_IDX_PRESCALE 4'h8
`define TIC_IDX_LAST 4'h8
// Reset values
`define TIC_RST_FLAGS 8'h00
`define TIC_RST_ENABLE 8'h00
`define TIC_RST_PRESET 8'h00
`define TIC_RST_RUN_CONTROL 1'h1
`define TIC_RST_PRESCALE 3'h0
// Function flag bit positions
`define TIC_BIT_TMR 0
`define TIC_BIT_EXT_A 1
`define TIC_BIT_EXT_B 2
`define TIC_BIT_KEY 3
// Usb flag bit positions
`define TIC_BIT_EP0_TX 0
`define TIC_BIT_EP0_RX 1
`define TIC_BIT_EP1_TX 2
`define TIC_BIT_EP2_TX 3
`define TIC_BIT_SETUP 6
`define TIC_BIT_SLEEP 7
// Implemented bits of each flag register
`define TIC_FUNC_MASK 8'h0f
`define TIC_USB_MASK 8'hcf
// Prescaler: code 0 divides by 2^3
`define TIC_PRESCALE_BASE 3
`define TIC_PRESCALE_W 10
`define TIC_TIMER_MAX 8'hff
`define TIC_TIMER_ZERO 8'h00
// Timing: 250 MHz clock, key report tick every 4 ms, power-on hold 5 ms
`define TIC_CLK_MHZ 250
`define TIC_KEY_TICK_US 4000
`define TIC_POR_US 5000
`define TIC_KEY_TICK_CYC (`TIC_KEY_TICK_US * `TIC_CLK_MHZ)
`define TIC_POR_CYC (`TIC_POR_US * `TIC_CLK_MHZ)
// Core clock is system clock divided by two
`define TIC_CORE_DIV 2
// Bus responses
`define TIC_RESP_OKAY 2'h0
`define TIC_RESP_SLVERR 2'h2
`endif

// >>> verilog/tic_pkg.sv
// Types shared by the timer interrupt controller files
package tic_pkg;
  typedef enum logic [1:0] {
    TIC_POR_HOLD = 2'b00,
    TIC_POR_RUN = 2'b01
  } tic_por_e;
  typedef logic [7:0] tic_byte_t;
endpackage

// >>> verilog/tic_falling_edge.sv
// Synchroniser and falling-edge detector for one external interrupt pin
`timescale 1ns/100ps
`default_nettype none
module tic_falling_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two stages settle the pin; only the second stage feeds the detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // One pulse per high-to-low transition
  assign fall = last_r & ~sync_r;
endmodule
`default_nettype wire

// >>> tb/tic_top_assertions.sv
// Port-level assertion checker for the timer interrupt controller, bound into tic_top
`timescale 1ns/100ps
`default_nettype none
module tic_top_checker #(
  parameter int POR_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_irq,
  input wire logic cpu_clk_en,
  input wire logic chip_reset_n
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Cycles since reset release, saturating so a long run never wraps
  logic [31:0] up_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_r <= 32'h0;
    else if (up_r != 32'hffffffff) up_r <= up_r + 32'h1;
  end

  // Power-on hold and quiet outputs while held
  hold_len_a: assert property ($rose(chip_reset_n) |-> up_r >= POR_CYC)
    else $error("chip reset released before the hold ran out");
  hold_quiet_a: assert property (!chip_reset_n |-> !cpu_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("output active during the reset hold");
  // Request stays up until a write (which may clear) has been answered
  irq_hold_a: assert property (cpu_irq && !$rose(s_axi_bvalid) |=> cpu_irq)
    else $error("interrupt request dropped without a write");
  clk_half_a: assert property (chip_reset_n && $past(chip_reset_n) |-> cpu_clk_en != $past(cpu_clk_en))
    else $error("core clock enable missed a toggle");
  // Bus answers and how long they stand
  b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && chip_reset_n |=> s_axi_bvalid) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready && chip_reset_n |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn or changed");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule

bind tic_top tic_top_checker #(.POR_CYC(POR_CYC)) tic_top_checker_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cpu_irq(cpu_irq), .cpu_clk_en(cpu_clk_en), .chip_reset_n(chip_reset_n));
`default_nettype wire

// >>> tb/tic_event_src.sv
// Behavioural model of the serial engine events and the two external pins
`timescale 1ns/100ps
`default_nettype none
module tic_event_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [3:0] sel,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic ep0_tx_done,
  output logic ep0_rx_done,
  output logic ep1_tx_done,
  output logic ep2_tx_done,
  output logic ep0_setup_done,
  output logic bus_sleep_flag
);
  logic [5:0] ev_r = 6'h00;
  logic [1:0] pin_r = 2'h3;
  logic [2:0] low_r = 3'h0;
  // Completion lines, one cycle each; pins idle high like pulled-up port pins
  assign {bus_sleep_flag, ep0_setup_done, ep2_tx_done, ep1_tx_done, ep0_rx_done, ep0_tx_done} = ev_r;
  assign {ext_irq_b, ext_irq_a} = pin_r;
  // Codes 6 and 7 pull a pin low for several cycles so the synchroniser sees it
  always @(posedge aclk) begin
    ev_r <= 6'h00;
    if (go && sel < 4'h6) ev_r <= 6'h01 << sel;
    if (go && sel >= 4'h6) begin
      pin_r[sel[0]] <= 1'b0;
      low_r <= 3'h4;
    end else if (low_r != 3'h0) low_r <= low_r - 3'h1;
    else pin_r <= 2'h3;
  end
endmodule
`default_nettype wire

// >>> tb/tic_top_tb.sv
// Self-checking testbench of the timer interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "tic_map.svh"
module tic_top_tb;
  localparam int KT = 20000;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
  logic [3:0] sel = 4'h0, s_axi_wstrb = 4'h1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_irq_a, ext_irq_b, ep0_tx_done, ep0_rx_done, ep1_tx_done, ep2_tx_done;
  logic ep0_setup_done, bus_sleep_flag, cpu_irq, cpu_clk_en, chip_reset_n;
  int fails = 0, num_checks = 0, cyc = 0, t0, c, k, n, p;
  logic [34:0] exp_r[$], er;
  logic [1:0] exp_b[$];
  logic [7:0] m;
  int pos[6] = '{0, 1, 2, 3, 6, 7};

  tic_top #(.KEY_TICK_CYC(KT), .POR_CYC(4)) tic_top_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_irq_a, .ext_irq_b, .ep0_tx_done, .ep0_rx_done, .ep1_tx_done, .ep2_tx_done,
    .ep0_setup_done, .bus_sleep_flag, .cpu_irq, .cpu_clk_en, .chip_reset_n);
  tic_event_src tic_event_src_inst (.aclk, .go, .sel, .ext_irq_a, .ext_irq_b, .ep0_tx_done,
    .ep0_rx_done, .ep1_tx_done, .ep2_tx_done, .ep0_setup_done, .bus_sleep_flag);

  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task test_done;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus master: releases each address or data when taken, accepts the answer late at random
  task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0,
                    input logic [3:0] s = 4'h1);
    exp_b.push_back(r);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    repeat ($urandom_range(0, 2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
    exp_r.push_back({r == `TIC_RESP_OKAY, r, 24'h0, d});
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    repeat ($urandom_range(0, 2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Ask the far-side model for one event and give it time to land in the flags
  task automatic ev(input logic [3:0] s);
    sel <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic wirq;
    do @(posedge aclk); while (cpu_irq !== 1'b1);
  endtask

  // Scoreboard: each answer on the bus is matched with the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) begin
      er = exp_r.pop_front();
      chk("rresp", {30'h0, er[33:32]}, {30'h0, s_axi_rresp});
      if (er[34]) chk("rdata", er[31:0], s_axi_rdata);
    end
  end

  // Watchdog sized well above the longest path through the tests
  initial begin
    repeat (95000) @(posedge aclk);
    fails++;
    $display("Error watchdog expired");
    test_done;
  end

  initial begin
    void'($urandom(95));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (chip_reset_n !== 1'b1);
    for (int i = 0; i < 9; i++) rd(4'(i), 8'h00);
    rd(4'h9, 8'h00, `TIC_RESP_SLVERR);
    wr(4'hf, 8'hff, `TIC_RESP_SLVERR);
    // Lane 0 strobe off: answered OKAY but the register keeps its value
    wr(`TIC_IDX_FUNC_ENABLE, 8'h0f, `TIC_RESP_OKAY, 4'h0);
    rd(`TIC_IDX_FUNC_ENABLE, 8'h00);
    // Every serial engine source: masked, enabled, write-0 then write-1 clear
    for (int j = 0; j < 6; j++) begin
      m = 8'h01 << pos[j];
      ev(4'(j));
      chk("irq masked", 32'h0, {31'h0, cpu_irq});
      rd(`TIC_IDX_USB_FLAGS, m);
      wr(`TIC_IDX_USB_ENABLE, m);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, cpu_irq});
      wr(`TIC_IDX_USB_CLEAR, ~m);
      rd(`TIC_IDX_USB_FLAGS, m);
      wr(`TIC_IDX_USB_CLEAR, m);
      wr(`TIC_IDX_USB_ENABLE, 8'h00);
      rd(`TIC_IDX_USB_FLAGS, 8'h00);
      chk("irq cleared", 32'h0, {31'h0, cpu_irq});
    end
    // Falling edges on both pins, each setting its flag once
    wr(`TIC_IDX_FUNC_ENABLE, 8'h06);
    ev(4'h6);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h02);
    ev(4'h7);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h06);
    chk("irq pins", 32'h1, {31'h0, cpu_irq});
    wr(`TIC_IDX_FUNC_CLEAR, 8'h06);
    repeat (8) @(posedge aclk);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h00);
    // Timer: random prescale code 0 to 2, preset near the top, then run
    k = $urandom_range(0, 2);
    n = $urandom_range(1, 4);
    p = 1 << (k + 3);
    wr(`TIC_IDX_PRESCALE, 8'(k));
    wr(`TIC_IDX_TIMER_PRESET, 8'(256 - n));
    rd(`TIC_IDX_PRESCALE, 8'(k));
    wr(`TIC_IDX_FUNC_ENABLE, 8'h01);
    wr(`TIC_IDX_RUN_CONTROL, 8'h00);
    c = 0;
    while (cpu_irq !== 1'b1 && c < 9000) begin
      @(posedge aclk);
      c++;
    end
    chk("overflow time", 32'h1, {31'h0, c + 6 >= n * p && c <= n * p + 3});
    rd(`TIC_IDX_FUNC_FLAGS, 8'h01);
    wr(`TIC_IDX_FUNC_CLEAR, 8'h01);
    repeat (256 * p + 8) @(posedge aclk);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h01);
    wr(`TIC_IDX_RUN_CONTROL, 8'h01);
    wr(`TIC_IDX_FUNC_CLEAR, 8'h01);
    repeat (256 * p + 8) @(posedge aclk);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h00);
    // Key report tick period, measured between two requests
    wr(`TIC_IDX_FUNC_ENABLE, 8'h08);
    wirq;
    t0 = cyc;
    wr(`TIC_IDX_FUNC_CLEAR, 8'h08);
    wirq;
    chk("tick period", 32'(KT), 32'(cyc - t0));
    // Second reset in mid-run: hold, then function enable, flags and request back to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("chip reset", 32'h0, {31'h0, chip_reset_n});
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    do @(posedge aclk); while (chip_reset_n !== 1'b1);
    rd(`TIC_IDX_FUNC_ENABLE, 8'h00);
    rd(`TIC_IDX_FUNC_FLAGS, 8'h00);
    chk("irq after reset", 32'h0, {31'h0, cpu_irq});
    test_done;
  end
endmodule
`default_nettype wire
